// ### rtl/inverter_drive_protection.sv
// Purpose: digital side of a transmitter inverter drive with protection
// Assumes: inputs synchronous to i_core_clk; adc bit comes from a SAR slice
// Notes:   one top module; all outputs registered
`default_nettype none
module inverter_drive_protection
	import inv_drive_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_chip_reset,
	input  wire logic                 i_enable_n,
	input  wire logic                 i_overcurrent_trip_level,
	input  wire logic [7:0]           i_die_temp_c,
	input  wire logic                 i_ping_phase,
	input  wire logic [9:0]           i_period_cyc,
	input  wire logic [9:0]           i_on_cyc,
	input  wire logic                 i_demod_filter_input,
	input  wire logic [2:0]           i_adc_chan,
	input  wire logic                 i_adc_cmp,
	input  wire logic [15:0]          i_otp_data,
	input  wire logic [GPIO_N-1:0]    i_gpio_set,
	output logic                      o_mcu_clk,
	output logic                      o_mcu_boot,
	output logic                      o_adc_clk,
	output logic [11:0]               o_adc_dac,
	output inv_drive_pkg::adc_result_t o_adc_result,
	output logic                      o_demod_bit,
	output logic [1:0]                o_otp_addr,
	output logic [63:0]               o_trim,
	output inv_drive_pkg::gate_t      o_gate,
	output inv_drive_pkg::status_t    o_status,
	output logic [GPIO_N-1:0]         o_gpio
);
	typedef enum logic [2:0] {S_SLEEP, S_OTP, S_REF, S_REG, S_RUN} seq_t;

	logic        rst;
	seq_t        seq_q, seq_d;
	logic [10:0] tmr_q, tmr_d;
	logic [2:0]  otp_q, otp_d;
	logic [63:0] trim_q, trim_d;
	logic        boot_q, boot_d;
	logic        hot_q, hot_d;
	status_t     st_q, st_d;
	logic [9:0]  ph_q, ph_d;
	logic [9:0]  per_q, per_d;
	logic [9:0]  on_q, on_d;
	logic        oc_q, oc_d;
	logic        pwm_q, pwm_d;
	logic [3:0]  dt_q, dt_d;
	gate_t       gate_q, gate_d;
	logic [2:0]  mck_q, mck_d;
	logic        mclk_q, mclk_d;
	logic [5:0]  adiv_q, adiv_d;
	logic        aclk_q, aclk_d;
	logic [3:0]  abit_q, abit_d;
	logic [11:0] asar_q, asar_d;
	logic [2:0]  ach_q, ach_d;
	adc_result_t ares_q, ares_d;
	logic [2:0]  dsh_q, dsh_d;
	logic        dbit_q, dbit_d;
	logic [GPIO_N-1:0] gpio_q, gpio_d;

	assign rst = !i_rst_n || i_chip_reset;

	// power sequencing and trim load
	always_comb begin
		seq_d  = seq_q;
		tmr_d  = tmr_q;
		otp_d  = otp_q;
		trim_d = trim_q;
		boot_d = 1'b0;
		case (seq_q)
			S_SLEEP: begin
				if (!i_enable_n) begin
					seq_d = S_OTP;
					otp_d = 3'h0;
				end
			end
			S_OTP: begin
				// otp read is combinational on the registered address
				trim_d[otp_q[1:0]*16 +: 16] = i_otp_data;
				otp_d = otp_q + 3'h1;
				if (otp_q == 3'(OTP_WORDS - 1)) begin
					seq_d = S_REF;
					tmr_d = 11'h000;
				end
			end
			S_REF, S_REG: begin
				tmr_d = tmr_q + 11'h001;
				if (tmr_q == 11'(SEQ_STEP_CYC - 1)) begin
					tmr_d = 11'h000;
					seq_d = (seq_q == S_REF) ? S_REG : S_RUN;
					boot_d = (seq_q == S_REG);
				end
			end
			S_RUN: ;
			default: seq_d = S_SLEEP;
		endcase
		// enable high forces sleep from any state
		if (i_enable_n)
			seq_d = S_SLEEP;
		// between the thresholds the flag holds its state
		hot_d = hot_q;
		if (i_die_temp_c > TEMP_HOT_C)
			hot_d = 1'b1;
		else if (i_die_temp_c < TEMP_COOL_C)
			hot_d = 1'b0;
		st_d.overcurrent = oc_q;
		st_d.overtemp    = hot_q;
		st_d.ref_on      = (seq_q == S_REF) || (seq_q == S_REG) || (seq_q == S_RUN);
		st_d.reg_on      = (seq_q == S_REG) || (seq_q == S_RUN);
		st_d.drive_on    = (seq_q == S_RUN) && !hot_q;
		st_d.asleep      = (seq_q == S_SLEEP);
		st_d.trim_done   = st_d.ref_on;
		gpio_d = st_d.asleep ? '0 : i_gpio_set;
	end

	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			seq_q  <= S_SLEEP;
			tmr_q  <= '0;
			otp_q  <= '0;
			trim_q <= '0;
			boot_q <= 1'b0;
			hot_q  <= 1'b0;
			st_q   <= '0;
			gpio_q <= '0;
		end else begin
			seq_q  <= seq_d;
			tmr_q  <= tmr_d;
			otp_q  <= otp_d;
			trim_q <= trim_d;
			boot_q <= boot_d;
			hot_q  <= hot_d;
			st_q   <= st_d;
			gpio_q <= gpio_d;
		end
	end

	// pwm, overcurrent and gate drive
	always_comb begin
		logic run;
		logic [9:0] p;
		logic [9:0] o;
		logic want_a;
		run = st_q.drive_on;
		p = i_ping_phase ? PING_PERIOD : i_period_cyc;
		// out-of-range periods are clamped rather than refused
		if (p < MIN_PERIOD)
			p = MIN_PERIOD;
		if (p > MAX_PERIOD)
			p = MAX_PERIOD;
		o = i_ping_phase ? {1'b0, p[9:1]} : i_on_cyc;
		if (!i_ping_phase && (p != MIN_PERIOD || o > {1'b0, p[9:1]}))
			o = {1'b0, p[9:1]};
		ph_d  = ph_q + 10'h001;
		per_d = per_q;
		on_d  = on_q;
		oc_d  = oc_q;
		// parked at all ones while stopped, so the first running edge wraps
		if (!run || ph_q >= per_q - 10'h001) begin
			ph_d  = run ? 10'h000 : 10'h3FF;
			per_d = p;
			on_d  = o;
			oc_d  = 1'b0;
		end
		// a trip in the wrap cycle keeps the flag: set beats re-arm
		if (run && i_overcurrent_trip_level)
			oc_d = 1'b1;
		pwm_d = run && (ph_d < on_d) && !oc_d;
		dt_d = (pwm_d != pwm_q) ? 4'(DEAD_CYC) : ((dt_q != 4'h0) ? dt_q - 4'h1 : 4'h0);
		// outside a trip, gates follow last cycle's pwm and each pwm edge waits out the dead time
		want_a = pwm_q;
		gate_d.hs_a = run && want_a && (dt_q == 4'h0) && !oc_d && !gate_q.ls_a;
		gate_d.ls_a = run && (oc_d || (!want_a && dt_q == 4'h0)) && !gate_d.hs_a;
		gate_d.hs_b = run && !want_a && !oc_d && (dt_q == 4'h0) && !gate_q.ls_b;
		gate_d.ls_b = run && want_a && (dt_q == 4'h0) && !gate_d.hs_b;
		if (gate_q.hs_a && gate_d.ls_a)
			gate_d.ls_a = 1'b0;
		if (gate_q.hs_b && gate_d.ls_b)
			gate_d.ls_b = 1'b0;
	end

	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			ph_q   <= '0;
			per_q  <= PING_PERIOD;
			on_q   <= '0;
			oc_q   <= 1'b0;
			pwm_q  <= 1'b0;
			dt_q   <= '0;
			gate_q <= '0;
		end else begin
			ph_q   <= ph_d;
			per_q  <= per_d;
			on_q   <= on_d;
			oc_q   <= oc_d;
			pwm_q  <= pwm_d;
			dt_q   <= dt_d;
			gate_q <= gate_d;
		end
	end

	// clocks, converter and demodulator
	always_comb begin
		// 100 MHz in, 40 MHz out as a 2-3 pattern
		mck_d  = (mck_q == 3'h4) ? 3'h0 : mck_q + 3'h1;
		mclk_d = (mck_d == 3'h0) || (mck_d == 3'h2);
		adiv_d = adiv_q + 6'h01;
		aclk_d = aclk_q;
		if (adiv_q == 6'(ADC_DIV - 1)) begin
			adiv_d = 6'h00;
			aclk_d = !aclk_q;
		end
		abit_d = abit_q;
		asar_d = asar_q;
		ach_d  = ach_q;
		ares_d = ares_q;
		ares_d.valid = 1'b0;
		// one sar decision per falling edge of the converter clock
		if (adiv_q == 6'(ADC_DIV - 1) && aclk_q) begin
			abit_d = (abit_q == 4'(ADC_CLKS_SAMPLE - 1)) ? 4'h0 : abit_q + 4'h1;
			if (abit_q == 4'h0) begin
				ach_d  = i_adc_chan;
				asar_d = 12'h800;
			end else if (abit_q <= 4'hC) begin
				if (!i_adc_cmp)
					asar_d[4'hC - abit_q] = 1'b0;
				if (abit_q != 4'hC)
					asar_d[4'hB - abit_q] = 1'b1;
			end
			if (abit_q == 4'hD) begin
				ares_d.valid = 1'b1;
				ares_d.chan  = ach_q;
				ares_d.data  = asar_q;
			end
		end
		dsh_d  = {dsh_q[1:0], i_demod_filter_input};
		dbit_d = dbit_q;
		if (dsh_q == 3'b111)
			dbit_d = 1'b1;
		else if (dsh_q == 3'b000)
			dbit_d = 1'b0;
	end

	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			mck_q  <= '0;
			mclk_q <= 1'b0;
			adiv_q <= '0;
			aclk_q <= 1'b0;
			abit_q <= '0;
			asar_q <= '0;
			ach_q  <= '0;
			ares_q <= '0;
			dsh_q  <= '0;
			dbit_q <= 1'b0;
		end else begin
			mck_q  <= mck_d;
			mclk_q <= mclk_d;
			adiv_q <= adiv_d;
			aclk_q <= aclk_d;
			abit_q <= abit_d;
			asar_q <= asar_d;
			ach_q  <= ach_d;
			ares_q <= ares_d;
			dsh_q  <= dsh_d;
			dbit_q <= dbit_d;
		end
	end

	assign o_mcu_clk    = mclk_q;
	assign o_mcu_boot   = boot_q;
	assign o_adc_clk    = aclk_q;
	assign o_adc_dac    = asar_q;
	assign o_adc_result = ares_q;
	assign o_demod_bit  = dbit_q;
	assign o_otp_addr   = otp_q[1:0];
	assign o_trim       = trim_q;
	assign o_gate       = gate_q;
	assign o_status     = st_q;
	assign o_gpio       = gpio_q;
endmodule
`default_nettype wire

// ### rtl/inv_drive_pkg.sv
// Purpose: shared constants and carriers for the inverter drive block
// Assumes: core clock of 100 MHz
// Notes:   periods are in core clock cycles
`default_nettype none
package inv_drive_pkg;
	localparam int unsigned CORE_CLK_HZ     = 100_000_000;
	localparam int unsigned DEAD_NS         = 100;
	localparam int unsigned DEAD_CYC        = (DEAD_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned PING_FREQ_HZ    = 175_000;
	localparam int unsigned MIN_FREQ_HZ     = 110_000;
	localparam int unsigned MAX_FREQ_HZ     = 205_000;
	localparam logic [9:0]  PING_PERIOD     = 10'(CORE_CLK_HZ / PING_FREQ_HZ);
	localparam logic [9:0]  MIN_PERIOD      = 10'((CORE_CLK_HZ + MAX_FREQ_HZ - 1) / MAX_FREQ_HZ);
	localparam logic [9:0]  MAX_PERIOD      = 10'(CORE_CLK_HZ / MIN_FREQ_HZ);
	localparam int unsigned MCU_CLK_HZ      = 40_000_000;
	localparam int unsigned ADC_CLK_HZ      = 1_000_000;
	localparam int unsigned ADC_DIV         = CORE_CLK_HZ / ADC_CLK_HZ / 2;
	localparam int unsigned ADC_CLKS_SAMPLE = 16;
	localparam int unsigned SEQ_STEP_US     = 10;
	localparam int unsigned SEQ_STEP_CYC    = SEQ_STEP_US * (CORE_CLK_HZ / 1_000_000);
	localparam int unsigned OTP_WORDS       = 4;
	localparam logic [7:0]  TEMP_HOT_C      = 8'h8C;
	localparam logic [7:0]  TEMP_COOL_C     = 8'h6E;
	localparam int unsigned GPIO_N          = 3;

	typedef struct packed {
		logic hs_a;
		logic ls_a;
		logic hs_b;
		logic ls_b;
	} gate_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
		logic [11:0] data;
	} adc_result_t;

	typedef struct packed {
		logic       overcurrent;
		logic       overtemp;
		logic       ref_on;
		logic       reg_on;
		logic       drive_on;
		logic       asleep;
		logic       trim_done;
	} status_t;
endpackage
`default_nettype wire

// ### tb/inv_drive_asserts.sv
// Purpose: port checks for the inverter drive
// Assumes: bound into inverter_drive_protection
// Notes: sees a subset of the top ports
`default_nettype none
module inv_drive_asserts
	import inv_drive_pkg::*;
(
	input wire logic                   i_core_clk,
	input wire logic                   i_rst_n,
	input wire logic                   i_chip_reset,
	input wire logic                   i_enable_n,
	input wire logic                   i_overcurrent_trip_level,
	input wire logic [7:0]             i_die_temp_c,
	input wire logic [GPIO_N-1:0]      o_gpio,
	input wire inv_drive_pkg::gate_t   o_gate,
	input wire inv_drive_pkg::status_t o_status
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	property p_leg; !(o_gate.hs_a && o_gate.ls_a) && !(o_gate.hs_b && o_gate.ls_b); endproperty
	a_leg: assert property (p_leg) else $error("leg overlap");
	property p_rst; i_chip_reset |=> o_gate == '0 && o_status == '0; endproperty
	a_rst: assert property (p_rst) else $error("reset leak");
	property p_slp; i_enable_n [*4] |-> o_gpio == '0 && o_gate == '0; endproperty
	a_slp: assert property (p_slp) else $error("awake in sleep");
	property p_ochs; o_status.overcurrent |-> !$past(o_gate.hs_a) && !$past(o_gate.hs_b);
	endproperty
	a_ochs: assert property (p_ochs) else $error("high side on in trip");
	property p_ocset; i_overcurrent_trip_level && o_status.drive_on && !o_status.overtemp
		&& !i_enable_n && !i_chip_reset |-> ##[1:3] o_status.overcurrent; endproperty
	a_ocset: assert property (p_ocset) else $error("trip flag missing");
	property p_hot; i_die_temp_c > TEMP_HOT_C && !i_chip_reset |-> ##[1:3] o_status.overtemp;
	endproperty
	a_hot: assert property (p_hot) else $error("no thermal stop");
	property p_hys; o_status.overtemp && $past(i_die_temp_c) >= TEMP_COOL_C && !i_chip_reset
		|=> o_status.overtemp; endproperty
	a_hys: assert property (p_hys) else $error("early thermal resume");
	property p_otoff; o_status.overtemp [*3] |-> o_gate == '0; endproperty
	a_otoff: assert property (p_otoff) else $error("drive while hot");
endmodule
bind inverter_drive_protection inv_drive_asserts inv_drive_asserts_i (.i_core_clk, .i_rst_n,
	.i_chip_reset, .i_enable_n, .i_overcurrent_trip_level, .i_die_temp_c, .o_gpio, .o_gate,
	.o_status);
`default_nettype wire

// ### tb/bridge_coil_model.sv
// Purpose: bridge and coil behind the gate drives
// Assumes: heavy load only trips while high side a conducts
// Notes: comparator is registered
`default_nettype none
module bridge_coil_model
	import inv_drive_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_load_fault,
	input  wire inv_drive_pkg::gate_t i_gate,
	output var logic                  o_trip
);
	timeunit 1ns;
	timeprecision 1ns;
	// current collapses once the high side opens
	always_ff @(posedge i_core_clk) begin
		o_trip <= i_load_fault && i_gate.hs_a;
	end
endmodule
`default_nettype wire

// ### tb/test_inverter_drive_protection.sv
// Purpose: self-checking bench for the inverter drive
// Assumes: bridge model on gates, rom on otp port
// Notes: drive at rising edge, sample at falling edge
`default_nettype none
module test_inverter_drive_protection;
	timeunit 1ns;
	timeprecision 1ns;
	import inv_drive_pkg::*;
	logic        clk, rst_n = 1'b0, crst = 1'b0, en_n = 1'b0, flt = 1'b0, ping = 1'b0;
	logic        dmi = 1'b0, trip, boot, mclk, aclk, dbit, mp, ap;
	logic [7:0]  temp = 8'h19;
	logic [9:0]  per = 10'h258, on = 10'h1FF;
	logic [2:0]  gset = 3'h5, gpio, ach = 3'h6;
	logic [1:0]  oa;
	logic [11:0] dac;
	logic [63:0] trim, ex;
	gate_t       gate;
	status_t     st;
	adc_result_t ar;
	int          num_errors = 0, checks_done = 0, w, hi, mr = 0, an = 0, boots = 0;
	wire  [12:0] obs = {ar.valid, dbit, gate, st};
	inverter_drive_protection inverter_drive_protection_i (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_chip_reset(crst), .i_enable_n(en_n), .i_overcurrent_trip_level(trip),
		.i_die_temp_c(temp), .i_ping_phase(ping), .i_period_cyc(per), .i_on_cyc(on),
		.i_demod_filter_input(dmi), .i_adc_chan(ach), .i_adc_cmp(12'h5A3 >= dac),
		.i_otp_data({6'h2B, oa, 6'h15, oa}), .i_gpio_set(gset), .o_mcu_clk(mclk),
		.o_mcu_boot(boot), .o_adc_clk(aclk), .o_adc_dac(dac), .o_adc_result(ar),
		.o_demod_bit(dbit), .o_otp_addr(oa), .o_trim(trim), .o_gate(gate), .o_status(st),
		.o_gpio(gpio));
	bridge_coil_model bridge_coil_model_i (.i_core_clk(clk), .i_load_fault(flt),
		.i_gate(gate), .o_trip(trip));
	always @(negedge clk) begin
		mr += int'(mclk === 1'b1 && mp === 1'b0);
		an += int'(aclk === 1'b1 && ap === 1'b0);
		boots += int'(boot === 1'b1);
		mp = mclk;
		ap = aclk;
	end
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task automatic chb(input logic g, input logic e);
		chk({63'h0, g}, {63'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wt(input int i, input logic v, input int lim);
		w = 0;
		if (clk === 1'b1)
			@(negedge clk);
		while (obs[i] !== v) begin
			@(negedge clk);
			w++;
			if (w > lim) begin
				num_errors++;
				summarize();
			end
		end
	endtask
	task automatic meas(input int e);
		wt(10, 1'b0, 2000);
		wt(10, 1'b1, 2000);
		wt(10, 1'b0, 2000);
		hi = w;
		wt(10, 1'b1, 2000);
		chk(64'(hi + w), 64'(e));
	endtask
	task automatic t_boot();
		wt(4, 1'b1, 100);
		chb(st.reg_on, 1'b0);
		wt(3, 1'b1, 2000);
		chb(w inside {[SEQ_STEP_CYC - 3:SEQ_STEP_CYC + 3]}, 1'b1);
		wt(2, 1'b1, 2000);
		for (int k = 0; k < 4; k++) ex[16*k +: 16] = {6'h2B, 2'(k), 6'h15, 2'(k)};
		chk(trim, ex);
		chb(st.trim_done, 1'b1);
		chk(64'(gpio), 64'h5);
	endtask
	task automatic t_freq();
		meas(600);
		@(posedge clk) per <= 10'h12C;
		@(posedge clk) on <= 10'h064;
		meas(MIN_PERIOD);
		chb(hi <= 100, 1'b1);
		@(posedge clk) per <= 10'h3FF;
		meas(MAX_PERIOD);
		chb(hi > 300, 1'b1);
		@(posedge clk) ping <= 1'b1;
		meas(PING_PERIOD);
		chb(hi inside {[PING_PERIOD / 2 - DEAD_CYC - 4:PING_PERIOD / 2]}, 1'b1);
		@(posedge clk) ping <= 1'b0;
		@(posedge clk) per <= 10'h258;
	endtask
	task automatic t_oc();
		wt(10, 1'b1, 2000);
		chk(64'(gate), 64'h9);
		@(posedge clk) flt <= 1'b1;
		wt(6, 1'b1, 10);
		cyc(15);
		chk(64'(gate), 64'h4);
		@(posedge clk) flt <= 1'b0;
		wt(6, 1'b0, 1000);
		wt(10, 1'b1, 400);
	endtask
	task automatic t_ot();
		@(posedge clk) temp <= 8'h8C;
		cyc(10);
		chb(st.overtemp, 1'b0);
		@(posedge clk) temp <= 8'h8D;
		wt(5, 1'b1, 10);
		@(posedge clk) temp <= 8'h6E;
		cyc(10);
		chb(st.overtemp, 1'b1);
		@(posedge clk) temp <= 8'h6D;
		wt(5, 1'b0, 10);
		wt(10, 1'b1, 2000);
	endtask
	task automatic t_rst();
		int b;
		@(posedge clk) en_n <= 1'b1;
		wt(1, 1'b1, 2000);
		@(posedge clk) en_n <= 1'b0;
		wt(2, 1'b1, 3000);
		b = boots;
		@(posedge clk) crst <= 1'b1;
		cyc(2);
		chk(64'({gate, st, gpio, dbit}), 64'h0);
		@(posedge clk) crst <= 1'b0;
		wt(2, 1'b1, 3000);
		chk(64'(boots - b), 64'h1);
	endtask
	task automatic t_misc();
		int m;
		int a;
		m = mr;
		a = an;
		cyc(1000);
		chb((mr - m) inside {[399:401]}, 1'b1);
		chb((an - a) inside {[9:11]}, 1'b1);
		wt(12, 1'b1, 4000);
		chk(64'({ar.chan, ar.data}), 64'h65A3);
		@(posedge clk) ach <= 3'h2;
		wt(12, 1'b1, 4000);
		chk(64'({ar.chan, ar.data}), 64'h25A3);
		@(posedge clk) dmi <= 1'b1;
		@(posedge clk) dmi <= 1'b0;
		cyc(5);
		chb(dbit, 1'b0);
		@(posedge clk) dmi <= 1'b1;
		wt(11, 1'b1, 10);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_boot();
		t_freq();
		t_oc();
		t_ot();
		t_rst();
		t_misc();
		summarize();
	end
endmodule
`default_nettype wire
